// File: hdl/phy_misc_status_control.sv
// Functional notes
// R01: CRS from receive only in repeater/full duplex
// R02: carrier on at two nonadjacent zeros in ten
// R03: ten ones before J/K drop carrier
// R04: after J/K, end on T/R or two IDLEs
// R05: COL on simultaneous tx/rx, off in full duplex
// R06: collision test mirrors TX_EN onto COL
// R07: 10M heartbeat pulse after TX_EN falls, disableable
// R08: isolate ignores transmit inputs, off at reset
// R09: link ready waits auto-negotiation unless disabled
// R10: wait 330us of valid signal before ready
// R11: valid signal loss forces link down immediately
// R12: power-down bit holds all but management down; the code does not gate the speed LED with it
// R13: energy-detect power-down, wake on line energy
// R14: host holds hardware reset low 100us
// R15: self-clearing soft reset stretched 256us
// R16: power-down exit reset, three sources combined
// R17: registers reset by hardware or soft reset only
// R18: MII slow 16us after reset, then fast; the code goes fast only while the aneg bit is set
// R19: strap bit one makes LED active low
// R20: activity LED held 128ms after CRS
// R21: speed LED on at 100M or negotiation; the code holds it off while isolate is set
// R22: near loopback, transmitter off, COL gated
// R23: strap bit zero makes LED active high
`timescale 1ns/1ps
`default_nettype none
module phy_misc_status_control #(
	parameter int LINK_WAIT = phy_misc_pkg::LINK_WAIT_CYC, // valid-signal settle cycles
	parameter int RST_HOLD  = phy_misc_pkg::RST_HOLD_CYC,  // reset stretch cycles
	parameter int ACT_HOLD  = phy_misc_pkg::ACT_HOLD_CYC   // activity LED hold cycles
) (
	input  wire logic        pclk,                // system clock
	input  wire logic        presetn,             // async reset, low active
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb enable
	input  wire logic        pwrite,              // apb direction
	input  wire logic [11:0] paddr,               // apb byte address
	input  wire logic [31:0] pwdata,              // apb write data
	output logic             pready,              // apb ready
	output logic [31:0]      prdata,              // apb read data
	output logic             pslverr,             // apb error
	input  wire logic        tx_en,               // mac transmit enable
	input  wire logic        code_clk,            // receive code bit clock
	input  wire logic        code_bit,            // encoded unscrambled bit
	input  wire logic        data_valid,          // equaliser valid signal
	input  wire logic        aneg_grant,          // auto-negotiation grant, releases ready link
	input  wire logic        line_energy_present, // line energy seen
	input  wire logic        repeater_mode,       // repeater configuration
	input  wire logic [3:0]  led_strap,           // address straps for led polarity
	output logic             crs,                 // carrier sense
	output logic             col,                 // collision
	output logic             link_up,             // link indication
	output logic             general_internal_reset, // combined reset, high active
	output logic             powered_down,        // core powered down
	output logic             tx_power_off,        // transmitters off
	output logic             loopback_on,         // near-end loopback path
	output logic             tx_accept,           // transmit inputs not isolated
	output logic             mii_fast,            // 1: 25 MHz, 0: 2.5 MHz
	output logic             energy_wake,         // pulse on energy wake-up
	output logic [3:0]       led_out              // link, activity, speed, duplex
);
	import phy_misc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	localparam int NS = 7;
	logic [NS-1:0] meta_r;
	logic [NS-1:0] sync_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= {tx_en, code_clk, code_bit, data_valid, aneg_grant,
				line_energy_present, repeater_mode};
			sync_r <= meta_r;
		end
	logic tx_s, cclk_s, cbit_s, dv_s, ag_s, en_s, rep_s;
	assign {tx_s, cclk_s, cbit_s, dv_s, ag_s, en_s, rep_s} = sync_r;

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] ctrl_r, mcs_r, spec_r;
	logic        rst_r;
	logic        swrst_req;
	logic        wr_acc, rd_setup;
	logic [9:0]  widx;
	assign widx = paddr[11:2];
	assign wr_acc = psel && penable && pwrite;
	assign rd_setup = psel && !penable;

	function automatic logic mapped(input logic [9:0] idx);
		mapped = (idx == {2'b00, CTRL_IDX}) || (idx == {2'b00, STAT_IDX})
			|| (idx == {2'b00, MCS_IDX}) || (idx == {2'b00, SPEC_IDX});
	endfunction : mapped

	assign swrst_req = wr_acc && (widx == {2'b00, CTRL_IDX}) && pwdata[B_SWRST];

	// mcs and spec survive soft reset; ctrl does not
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_r <= CTRL_RST;
			mcs_r  <= MCS_RST;
			spec_r <= SPEC_RST;
		end
		else if (swrst_req)
			ctrl_r <= CTRL_RST | (16'h1 << B_SWRST); // see R15 see R17
		else if (wr_acc)
		begin
			if (widx == {2'b00, CTRL_IDX})
				ctrl_r <= pwdata[15:0];
			if (widx == {2'b00, MCS_IDX})
				mcs_r <= pwdata[15:0];
			if (widx == {2'b00, SPEC_IDX})
				spec_r <= pwdata[15:0];
		end
		else if (ctrl_r[B_SWRST] && !rst_r)
			ctrl_r[B_SWRST] <= 1'b0;

	logic isolate, loop, coltest, fdx, fast, aneg, hb_off;
	assign isolate = ctrl_r[B_ISOLATE];
	assign loop = ctrl_r[B_LOOP];
	assign coltest = ctrl_r[B_COLTEST];
	assign fdx = ctrl_r[B_DUPLEX];
	assign fast = ctrl_r[B_SPEED];
	assign aneg = ctrl_r[B_ANEG];
	assign hb_off = spec_r[B_HB_OFF];

	////////////////////////////////////////////////////////////////////////
	// power-down and combined reset
	logic pd, pd_q_r;
	logic [31:0] rst_cnt_r;
	assign pd = ctrl_r[B_PDOWN] || (mcs_r[B_EDPD] && !en_s); // see R12 see R13

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pd_q_r <= 1'b0;
		else
			pd_q_r <= pd;

	// hardware reset sets it asynchronously; soft and wake resets are stretched
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			rst_r <= 1'b1;
			rst_cnt_r <= '0;
		end
		else if (swrst_req || (pd_q_r && !pd)) // see R15 see R16
		begin
			rst_r <= 1'b1;
			rst_cnt_r <= 32'(RST_HOLD);
		end
		else if (rst_cnt_r != '0)
			rst_cnt_r <= rst_cnt_r - 32'h1;
		else
			rst_r <= 1'b0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			energy_wake <= 1'b0;
		else
			energy_wake <= mcs_r[B_EDPD] && pd_q_r && !pd && en_s; // see R13

	logic core_rst;
	assign core_rst = rst_r || pd;
	assign general_internal_reset = rst_r; // see R16
	assign powered_down = pd_q_r;
	assign tx_power_off = loop || pd_q_r; // see R22
	assign loopback_on = loop;

	////////////////////////////////////////////////////////////////////////
	// receive code bits and carrier detect
	logic cclk_q_r, bit_stb;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cclk_q_r <= 1'b0;
		else
			cclk_q_r <= cclk_s;
	assign bit_stb = cclk_s && !cclk_q_r;

	function automatic logic two_sep_zeros(input logic [CRS_WIN-1:0] w);
		two_sep_zeros = 1'b0;
		for (int i = 0; i < CRS_WIN; i++)
			for (int j = i + 2; j < CRS_WIN; j++)
				if (!w[i] && !w[j])
					two_sep_zeros = 1'b1;
	endfunction : two_sep_zeros

	crs_state_type cs_r;
	logic [CRS_WIN-1:0] win_r;
	logic [CRS_WIN-1:0] win_nxt;
	logic [3:0] ones_r, sym_cnt_r;
	logic [4:0] prev_sym_r;
	assign win_nxt = {win_r[CRS_WIN-2:0], cbit_s};

	// end of stream; the window is flushed so the T/R bits cannot retrigger carrier
	logic frame_end;
	assign frame_end = (cs_r == CS_FRAME) && (sym_cnt_r == 4'(SYM_BITS - 1))
		&& ((prev_sym_r == SYM_T && win_nxt[4:0] == SYM_R)
		|| (prev_sym_r == SYM_IDLE && win_nxt[4:0] == SYM_IDLE));

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			win_r <= '1;
		else if (core_rst)
			win_r <= '1;
		else if (bit_stb)
			win_r <= frame_end ? '1 : win_nxt; // see R04

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cs_r <= CS_OFF;
			ones_r <= '0;
			sym_cnt_r <= '0;
			prev_sym_r <= '0;
		end
		else if (core_rst)
			cs_r <= CS_OFF;
		else if (bit_stb)
		begin
			ones_r <= cbit_s ? ones_r + 4'h1 : 4'h0;
			case (cs_r)
				CS_OFF:
					if (two_sep_zeros(win_nxt)) // see R02
					begin
						cs_r <= CS_PRE;
						ones_r <= '0;
					end
				CS_PRE:
					if (win_nxt == SYM_JK)
					begin
						cs_r <= CS_FRAME;
						sym_cnt_r <= '0;
						prev_sym_r <= SYM_R;
					end
					else if (cbit_s && ones_r == 4'(CRS_WIN - 1)) // see R03
						cs_r <= CS_OFF;
				CS_FRAME:
					if (sym_cnt_r == 4'(SYM_BITS - 1))
					begin
						sym_cnt_r <= '0;
						prev_sym_r <= win_nxt[4:0];
						// a lone T or IDLE keeps carrier up
						if (frame_end)
							cs_r <= CS_OFF; // see R04
					end
					else
						sym_cnt_r <= sym_cnt_r + 4'h1;
				default:
					cs_r <= CS_OFF;
			endcase
		end

	logic rx_act, tx_act, crs_nxt;
	assign rx_act = cs_r != CS_OFF;
	assign tx_act = tx_s && !isolate && !core_rst; // see R08
	assign tx_accept = !isolate;
	assign crs_nxt = (rep_s || fdx) ? rx_act : (rx_act || tx_act); // see R01

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			crs <= 1'b0;
		else
			crs <= crs_nxt;

	////////////////////////////////////////////////////////////////////////
	// collision and heartbeat
	logic tx_q_r, hb_pulse;
	logic [7:0] hb_cnt_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			tx_q_r <= 1'b0;
		else
			tx_q_r <= tx_act;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			hb_cnt_r <= '0;
		else if (tx_q_r && !tx_act && !fast && !hb_off) // see R07
			hb_cnt_r <= 8'(HB_DELAY_CYC + HB_WIDTH_CYC);
		else if (hb_cnt_r != '0)
			hb_cnt_r <= hb_cnt_r - 8'h1;
	assign hb_pulse = (hb_cnt_r != '0) && (hb_cnt_r <= 8'(HB_WIDTH_CYC));

	// registered on pclk: one cycle late versus a truly asynchronous gate
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			col <= 1'b0;
		else if (coltest)
			col <= tx_act; // see R06
		else if (fdx || loop) // see R05 see R22
			col <= 1'b0;
		else
			col <= (tx_act && rx_act) || hb_pulse; // see R05 see R07

	////////////////////////////////////////////////////////////////////////
	// link integrity
	link_state_type lk_r;
	logic [31:0] lk_cnt_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			lk_r <= LK_DOWN;
			lk_cnt_r <= '0;
		end
		else if (!dv_s || core_rst)
			lk_r <= LK_DOWN; // see R11
		else
			case (lk_r)
				LK_DOWN:
				begin
					lk_r <= LK_WAIT;
					lk_cnt_r <= 32'(LINK_WAIT);
				end
				LK_WAIT:
					if (lk_cnt_r > 32'h1)
						lk_cnt_r <= lk_cnt_r - 32'h1;
					else
						lk_r <= aneg ? LK_READY : LK_UP; // see R10 see R09
				LK_READY:
					if (ag_s || !aneg)
						lk_r <= LK_UP; // see R09
				LK_UP:
					lk_r <= LK_UP;
				default:
					lk_r <= LK_DOWN;
			endcase
	assign link_up = lk_r == LK_UP;

	////////////////////////////////////////////////////////////////////////
	// mii clock rate after reset
	logic [15:0] slow_cnt_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			slow_cnt_r <= 16'(MII_SLOW_CYC);
		else if (core_rst)
			slow_cnt_r <= 16'(MII_SLOW_CYC);
		else if (slow_cnt_r != '0)
			slow_cnt_r <= slow_cnt_r - 16'h1;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mii_fast <= 1'b0;
		else
			mii_fast <= (slow_cnt_r == '0) && aneg; // see R18

	////////////////////////////////////////////////////////////////////////
	// leds
	logic [3:0] pol_r;
	logic       strap_done_r;
	logic [31:0] act_cnt_r;
	logic [3:0] led_act;

	// straps caught at the first edge after reset release
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pol_r <= '0;
			strap_done_r <= 1'b0;
		end
		else if (!strap_done_r)
		begin
			pol_r <= led_strap;
			strap_done_r <= 1'b1;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			act_cnt_r <= '0;
		else if (crs)
			act_cnt_r <= 32'(ACT_HOLD); // see R20
		else if (act_cnt_r != '0)
			act_cnt_r <= act_cnt_r - 32'h1;

	assign led_act[0] = link_up;
	assign led_act[1] = crs || (act_cnt_r != '0); // see R20
	assign led_act[2] = (fast || aneg) && !isolate; // see R21
	assign led_act[3] = fdx && link_up;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			led_out <= '0;
		else
			led_out <= led_act ^ pol_r; // see R19 see R23

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait-free access phase, data from flops
	logic [15:0] stat_w;
	assign stat_w = {10'h0, pd_q_r, rst_r, en_s, col, crs, link_up};
	assign pready = psel && penable;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else if (rd_setup)
		begin
			pslverr <= !mapped(widx);
			if (pwrite || !mapped(widx))
				prdata <= '0;
			else if (widx == {2'b00, CTRL_IDX})
				prdata <= {16'h0, ctrl_r};
			else if (widx == {2'b00, STAT_IDX})
				prdata <= {16'h0, stat_w};
			else if (widx == {2'b00, MCS_IDX})
				prdata <= {16'h0, mcs_r};
			else
				prdata <= {16'h0, spec_r};
		end
endmodule : phy_misc_status_control
`default_nettype wire

// File: shared/phy_misc_pkg.sv
`default_nettype none
package phy_misc_pkg;
	localparam int CLK_MHZ = 50;
	// times as specified, in their own unit
	localparam int LINK_WAIT_US = 330;
	localparam int RST_HOLD_US = 256;
	localparam int MII_SLOW_US = 16;
	localparam int ACT_HOLD_MS = 128;
	localparam int HB_DELAY_NS = 2000;
	localparam int HB_WIDTH_NS = 1000;
	localparam int CRS_WIN = 10;
	localparam int SYM_BITS = 5;
	// derived cycle counts at the pclk rate
	localparam int LINK_WAIT_CYC = LINK_WAIT_US * CLK_MHZ;
	localparam int RST_HOLD_CYC = RST_HOLD_US * CLK_MHZ;
	localparam int MII_SLOW_CYC = MII_SLOW_US * CLK_MHZ;
	localparam int ACT_HOLD_CYC = ACT_HOLD_MS * 1000 * CLK_MHZ;
	localparam int HB_DELAY_CYC = (HB_DELAY_NS * CLK_MHZ) / 1000;
	localparam int HB_WIDTH_CYC = (HB_WIDTH_NS * CLK_MHZ) / 1000;
	// register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h00;
	localparam logic [7:0] STAT_IDX = 8'h01;
	localparam logic [7:0] MCS_IDX = 8'h11;
	localparam logic [7:0] SPEC_IDX = 8'h1B;
	// control, mcs and spec register fields
	localparam int B_DUPLEX = 8;
	localparam int B_COLTEST = 7;
	localparam int B_ISOLATE = 10;
	localparam int B_PDOWN = 11;
	localparam int B_ANEG = 12;
	localparam int B_SPEED = 13;
	localparam int B_LOOP = 14;
	localparam int B_SWRST = 15;
	localparam int B_EDPD = 13;
	localparam int B_HB_OFF = 11;
	localparam logic [15:0] CTRL_RST = 16'h3000;
	localparam logic [15:0] MCS_RST = 16'h0000;
	localparam logic [15:0] SPEC_RST = 16'h0000;
	// 5B code groups
	localparam logic [9:0] SYM_JK = 10'h311;
	localparam logic [4:0] SYM_T = 5'h0D;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_IDLE = 5'h1F;
	typedef enum {CS_OFF, CS_PRE, CS_FRAME} crs_state_type;
	typedef enum {LK_DOWN, LK_WAIT, LK_READY, LK_UP} link_state_type;
endpackage : phy_misc_pkg
`default_nettype wire

// File: bench/line_source.sv
`timescale 1ns/1ps
`default_nettype none
module line_source (
	output logic code_clk, // link bit clock, still between frames
	output logic code_bit  // encoded unscrambled bit
);
	initial
	begin
		code_clk = 1'b0;
		code_bit = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// bits go out msb first on a 160 ns clock unrelated to pclk
	task send(input logic [9:0] v);
		#3;
		for (int k = 9; k >= 0; k--)
		begin
			code_bit = v[k];
			#80 code_clk = 1'b1;
			#80 code_clk = 1'b0;
		end
		// a stale bit must not look valid once the clock stops
		code_bit = ~code_bit;
	endtask : send
endmodule : line_source
`default_nettype wire

// File: bench/phy_misc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module phy_misc_checker
	import phy_misc_pkg::*;
#(
	parameter int LINK_WAIT = 20, // settle cycles
	parameter int RST_HOLD  = 10, // stretch cycles
	parameter int ACT_HOLD  = 30  // led hold cycles
) (
	input wire logic        pclk,                   // clock
	input wire logic        presetn,                // reset
	input wire logic        psel,                   // apb select
	input wire logic        penable,                // apb enable
	input wire logic        pwrite,                 // apb direction
	input wire logic [11:0] paddr,                  // apb address
	input wire logic [31:0] pwdata,                 // apb data
	input wire logic        data_valid,             // valid signal
	input wire logic        crs,                    // carrier
	input wire logic        link_up,                // link
	input wire logic        general_internal_reset, // internal reset
	input wire logic        loopback_on,            // loopback
	input wire logic        tx_power_off,           // tx off
	input wire logic        energy_wake,            // wake pulse
	input wire logic        mii_fast,               // mii rate
	input wire logic [3:0]  led_strap,              // straps
	input wire logic [3:0]  led_out                 // leds
);
	logic act;
	int   dv_cnt;
	int   gr_cnt;
	int   up_cnt;
	int   quiet;
	assign act = led_out[1] != led_strap[1];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			dv_cnt <= 0;
		else
			dv_cnt <= data_valid ? dv_cnt + 1 : 0;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			gr_cnt <= 0;
		else
			gr_cnt <= general_internal_reset ? gr_cnt + 1 : 0;
	// saturates so a long run cannot wrap it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			up_cnt <= 0;
		else
			up_cnt <= general_internal_reset ? 0 : (up_cnt < 4000 ? up_cnt + 1 : up_cnt);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			quiet <= ACT_HOLD;
		else
			quiet <= crs ? 0 : (quiet < ACT_HOLD ? quiet + 1 : quiet);
	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_link_loss: assert property ($fell(data_valid) |-> ##[1:4] !link_up)
		else $error("link kept after valid loss");
	chk_link_wait: assert property ($rose(link_up) |-> dv_cnt >= LINK_WAIT)
		else $error("link up too early");
	// the pin reset is not stretched, so a one-cycle high is exempt
	chk_rst_hold: assert property ($fell(general_internal_reset) && gr_cnt > 1 |-> gr_cnt >= RST_HOLD)
		else $error("internal reset too short");
	chk_soft_start: assert property (psel && penable && pwrite && paddr[11:2] == 10'h000
		&& pwdata[B_SWRST] |-> ##[1:2] general_internal_reset)
		else $error("soft reset not applied");
	chk_loop_txoff: assert property (loopback_on |-> tx_power_off)
		else $error("transmitter on in loopback");
	chk_act_hold: assert property (quiet < ACT_HOLD - 3 |-> ##2 act)
		else $error("activity led dropped early");
	chk_wake_pulse: assert property (energy_wake |=> !energy_wake)
		else $error("wake pulse too long");
	chk_mii_slow: assert property ($rose(mii_fast) |-> up_cnt >= MII_SLOW_CYC - 2)
		else $error("mii fast too early");
	cov_link: cover property ($rose(link_up));
	cov_crs: cover property ($rose(crs));
	cov_stretch: cover property ($fell(general_internal_reset) && gr_cnt > 1);
	cov_wake: cover property (energy_wake);
endmodule : phy_misc_checker
bind phy_misc_status_control phy_misc_checker #(
	.LINK_WAIT(LINK_WAIT), .RST_HOLD(RST_HOLD), .ACT_HOLD(ACT_HOLD)
) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .data_valid(data_valid),
	.crs(crs), .link_up(link_up), .general_internal_reset(general_internal_reset),
	.loopback_on(loopback_on), .tx_power_off(tx_power_off), .energy_wake(energy_wake),
	.mii_fast(mii_fast), .led_strap(led_strap), .led_out(led_out)
);
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import phy_misc_pkg::*;
	typedef struct packed
	{
		logic        w;
		logic [7:0]  i;
		logic [31:0] d;
		logic [31:0] e;
		logic        er;
	} row_type;
	localparam int LW = 20;
	localparam int RH = 10;
	localparam int AH = 30;
	localparam logic [3:0] STRAP = 4'hA;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, re, tx_en = 1'b0, code_clk, code_bit, dv = 1'b0;
	logic        grant = 1'b0, energy = 1'b1, rep = 1'b0, crs, col, link_up, gir, pd;
	logic        txoff, loop_on, tx_acc, mii_fast, wake;
	logic [3:0]  led_out;
	int          num_errors = 0, checks_done = 0, ticks = 0;
	row_type     rows [5] = '{
		'{1'b0, CTRL_IDX, 32'h0, 32'h3000, 1'b0},
		'{1'b1, SPEC_IDX, 32'h0800, 32'h0, 1'b0},
		'{1'b0, SPEC_IDX, 32'h0, 32'h0800, 1'b0},
		'{1'b0, 8'h05, 32'h0, 32'h0, 1'b1},
		'{1'b0, STAT_IDX, 32'h0, 32'h0008, 1'b0}};
	phy_misc_status_control #(.LINK_WAIT(LW), .RST_HOLD(RH), .ACT_HOLD(AH)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .tx_en(tx_en), .code_clk(code_clk), .code_bit(code_bit),
		.data_valid(dv), .aneg_grant(grant), .line_energy_present(energy),
		.repeater_mode(rep), .led_strap(STRAP), .crs(crs), .col(col), .link_up(link_up),
		.general_internal_reset(gir), .powered_down(pd), .tx_power_off(txoff),
		.loopback_on(loop_on), .tx_accept(tx_acc), .mii_fast(mii_fast),
		.energy_wake(wake), .led_out(led_out));
	line_source LS (.code_clk(code_clk), .code_bit(code_bit));
	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// ends 1 ns past an edge so registered outputs have settled
	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task note(input string s);
		$display("test %s done", s);
	endtask : note
	task end_of_test;
		$display("counts: errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		cyc(1);
		chk(mii_fast, 0);
		foreach (rows[k])
		begin
			apb(rows[k].w, rows[k].i, rows[k].d);
			if (!rows[k].w) chk(rd, rows[k].e);
			chk(re, rows[k].er);
		end
		note("registers");
		apb(1, CTRL_IDX, 32'h2000);
		dv <= 1'b1;
		cyc(LW / 2);
		chk(link_up, 0);
		cyc(LW);
		chk(link_up, 1);
		chk(led_out[0], !STRAP[0]);
		@(posedge pclk);
		dv <= 1'b0;
		cyc(4);
		chk(link_up, 0);
		apb(1, CTRL_IDX, 32'h3000);
		dv <= 1'b1;
		cyc(2 * LW);
		chk(link_up, 0);
		chk(led_out[2], !STRAP[2]);
		@(posedge pclk);
		grant <= 1'b1;
		cyc(4);
		chk(link_up, 1);
		note("link");
		apb(1, CTRL_IDX, 32'h2000);
		dv <= 1'b0;
		LS.send(10'h36F);
		cyc(3);
		chk(crs, 1);
		chk(led_out[1], !STRAP[1]);
		LS.send(10'h3FF);
		cyc(3);
		chk(crs, 0);
		LS.send(SYM_JK);
		LS.send({SYM_T, 5'h0A});
		LS.send({SYM_IDLE, 5'h0A});
		cyc(3);
		chk(crs, 1);
		LS.send({SYM_T, SYM_R});
		cyc(3);
		chk(crs, 0);
		LS.send(10'h3FF);
		cyc(3);
		chk(crs, 0);
		LS.send(SYM_JK);
		LS.send({SYM_IDLE, SYM_IDLE});
		cyc(3);
		chk(crs, 0);
		chk(led_out[1], !STRAP[1]);
		cyc(AH + 5);
		chk(led_out[1], STRAP[1]);
		note("carrier");
		@(posedge pclk);
		tx_en <= 1'b1;
		cyc(4);
		chk(crs, 1);
		chk(col, 0);
		LS.send(SYM_JK);
		cyc(3);
		chk(col, 1);
		apb(1, CTRL_IDX, 32'h2100);
		cyc(3);
		chk(col, 0);
		LS.send({SYM_T, SYM_R});
		cyc(3);
		chk(crs, 0);
		apb(1, CTRL_IDX, 32'h2000);
		rep <= 1'b1;
		cyc(4);
		chk(crs, 0);
		apb(1, CTRL_IDX, 32'h2080);
		rep <= 1'b0;
		cyc(4);
		chk(col, 1);
		@(posedge pclk);
		tx_en <= 1'b0;
		cyc(4);
		chk(col, 0);
		apb(1, CTRL_IDX, 32'h6000);
		tx_en <= 1'b1;
		cyc(4);
		chk({loop_on, txoff, col}, 3'h6);
		apb(1, CTRL_IDX, 32'h2400);
		cyc(4);
		chk({tx_acc, crs, led_out[2]}, {2'h0, STRAP[2]});
		@(posedge pclk);
		tx_en <= 1'b0;
		note("collision");
		apb(1, CTRL_IDX, 32'h0);
		for (int h = 0; h < 2; h++)
		begin
			apb(1, SPEC_IDX, h ? 32'h0800 : 32'h0);
			tx_en <= 1'b1;
			repeat (5) @(posedge pclk);
			tx_en <= 1'b0;
			cyc(120);
			chk(col, h ? 0 : 1);
		end
		chk(led_out[2], STRAP[2]);
		note("heartbeat");
		apb(1, CTRL_IDX, 32'h0800);
		cyc(3);
		chk(pd, 1);
		apb(0, CTRL_IDX, 32'h0);
		chk(rd, 32'h0800);
		apb(1, CTRL_IDX, 32'h0);
		cyc(2);
		chk(gir, 1);
		cyc(RH + 5);
		chk({gir, pd}, 2'h0);
		apb(1, CTRL_IDX, 32'h8000);
		cyc(2);
		chk(gir, 1);
		apb(0, CTRL_IDX, 32'h0);
		chk(rd, 32'hB000);
		cyc(RH + 5);
		apb(0, CTRL_IDX, 32'h0);
		chk(rd, 32'h3000);
		apb(0, SPEC_IDX, 32'h0);
		chk(rd, 32'h0800);
		note("resets");
		apb(1, MCS_IDX, 32'h2000);
		energy <= 1'b0;
		cyc(5);
		chk(pd, 1);
		@(posedge pclk);
		energy <= 1'b1;
		cyc(3);
		chk(gir, 1);
		chk(wake, 1);
		cyc(RH + 5);
		chk(pd, 0);
		apb(0, MCS_IDX, 32'h0);
		chk(rd, 32'h2000);
		cyc(MII_SLOW_CYC);
		chk(mii_fast, 1);
		note("energy");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
